/* File: core/opmhc_pkg.sv */
// types for the operating mode controller
package opmhc_pkg;
   typedef enum logic [2:0] {
      OPMHC_INIT = 3'h0,
      OPMHC_NORMAL = 3'h1,
      OPMHC_STOP = 3'h3,
      OPMHC_SLEEP = 3'h2,
      OPMHC_RESTART = 3'h6,
      OPMHC_FAILSAFE = 3'h7
   } opmhc_mode_t;
endpackage

/* File: core/opmhc_regs.svh */
// frame encodings and timing counts for the operating mode controller
`ifndef OPMHC_REGS_SVH
`define OPMHC_REGS_SVH
`define OPMHC_CLK_MHZ 250
`define OPMHC_RST_DELAY_US 10
`define OPMHC_RST_DELAY_CYC (`OPMHC_RST_DELAY_US * `OPMHC_CLK_MHZ)
`define OPMHC_RST_PULSE_US 2
`define OPMHC_RST_PULSE_CYC (`OPMHC_RST_PULSE_US * `OPMHC_CLK_MHZ)
`define OPMHC_CRC_ON_FRAME 32'h67AA_AA0E
`define OPMHC_CRC_OFF_FRAME 32'hE7AA_AAC3
`endif

/* File: core/opmhc_top.sv */
// operating mode state machine with strap sampling and crc enable control
`timescale 1ns/100ps
`include "opmhc_regs.svh"
module opmhc_top #(
   parameter int RST_DELAY_CYC = `OPMHC_RST_DELAY_CYC,
   parameter int RST_PULSE_CYC = `OPMHC_RST_PULSE_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_soft_reset,
   input wire logic i_go_normal,
   input wire logic i_go_stop,
   input wire logic i_go_sleep,
   input wire logic i_wake,
   input wire logic i_wd_fail,
   input wire logic i_undervoltage,
   input wire logic i_critical_fail,
   input wire logic i_wd_reset_reenable,
   input wire logic i_spi_frame_valid,
   input wire logic [31:0] i_spi_frame,
   input wire logic i_test_pin,
   input wire logic i_pwm_in1_checksum_strap_pin,
   output opmhc_pkg::opmhc_mode_t o_mode,
   output logic o_main_regulator_output,
   output logic o_micro_reset_out_n,
   output logic o_int_out,
   output logic o_int_out_oe,
   output logic o_wd_long_window,
   output logic o_dev_mode,
   output logic o_crc_en
);
   import opmhc_pkg::*;

   opmhc_mode_t mode_r, mode_nxt;
   logic test_s1_r, test_s2_r, crc_s1_r, crc_s2_r;
   logic [31:0] cnt_r;
   logic rst_n_r;
   logic dev_r, dev_window_r, wd_rst_en_r;
   logic crc_r, int_r, wd_long_r, reg_on_r;
   logic rst_rise;

   // pins from outside the clock domain pass two flops first
   always_ff @(posedge i_clk) begin
      test_s1_r <= i_test_pin;
      test_s2_r <= test_s1_r;
      crc_s1_r <= i_pwm_in1_checksum_strap_pin;
      crc_s2_r <= crc_s1_r;
   end

   always_comb begin
      mode_nxt = mode_r;
      case (mode_r)
         OPMHC_INIT, OPMHC_RESTART: begin
            if (rst_rise)
               mode_nxt = OPMHC_NORMAL;
         end
         OPMHC_NORMAL: begin
            if (i_go_sleep)
               mode_nxt = OPMHC_SLEEP;
            else if (i_go_stop)
               mode_nxt = OPMHC_STOP;
         end
         OPMHC_STOP: begin
            if (i_go_normal)
               mode_nxt = OPMHC_NORMAL;
         end
         OPMHC_SLEEP, OPMHC_FAILSAFE: begin
            if (i_wake)
               mode_nxt = OPMHC_RESTART;
         end
         default: mode_nxt = OPMHC_INIT;
      endcase
      if (mode_r != OPMHC_SLEEP && mode_r != OPMHC_FAILSAFE &&
          mode_r != OPMHC_INIT && mode_r != OPMHC_RESTART) begin
         if (i_undervoltage || (i_wd_fail && (!dev_r || wd_rst_en_r)))
            mode_nxt = OPMHC_RESTART;
      end
      if (i_soft_reset)
         mode_nxt = OPMHC_INIT;
      if (i_critical_fail)
         mode_nxt = OPMHC_FAILSAFE;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst)
         mode_r <= OPMHC_INIT;
      else
         mode_r <= mode_nxt;
   end

   // reset output: held low through the reset delay of init and restart
   // only init and restart release the micro; sleep and fail-safe hold it
   assign rst_rise = !rst_n_r &&
                     (mode_r == OPMHC_INIT || mode_r == OPMHC_RESTART) &&
                     cnt_r == 32'(RST_DELAY_CYC - 1);
   always_ff @(posedge i_clk) begin
      if (i_rst || mode_nxt != mode_r)
         cnt_r <= 32'h0000_0000;
      else if (!rst_n_r && cnt_r != 32'(RST_DELAY_CYC - 1))
         cnt_r <= cnt_r + 32'h0000_0001;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst)
         rst_n_r <= 1'b0;
      else if (mode_nxt == OPMHC_INIT || mode_nxt == OPMHC_RESTART ||
               mode_nxt == OPMHC_SLEEP || mode_nxt == OPMHC_FAILSAFE)
         rst_n_r <= (mode_nxt == mode_r) ? (rst_n_r | rst_rise) : 1'b0;
      else
         rst_n_r <= 1'b1;
   end

   // regulator stays on in stop, off in sleep and fail-safe
   always_ff @(posedge i_clk) begin
      if (i_rst)
         reg_on_r <= 1'b1;
      else
         reg_on_r <= !(mode_nxt == OPMHC_SLEEP ||
                       mode_nxt == OPMHC_FAILSAFE);
   end

   // crc strap caught at reset release, low level enables crc
   always_ff @(posedge i_clk) begin
      if (i_rst)
         crc_r <= 1'b0;
      else if (rst_rise)
         crc_r <= !crc_s2_r;
      else if (i_spi_frame_valid && mode_r == OPMHC_NORMAL) begin
         if (i_spi_frame == `OPMHC_CRC_ON_FRAME)
            crc_r <= 1'b1;
         else if (i_spi_frame == `OPMHC_CRC_OFF_FRAME)
            crc_r <= 1'b0;
      end
   end

   // dev mode watch window only opens at i_rst, not at a soft reset into init
   // init hands over to normal at reset release, so the window runs on
   // until the first frame or the first move out of init and normal after that
   always_ff @(posedge i_clk) begin
      if (i_rst)
         dev_window_r <= 1'b1;
      else if (dev_r || (rst_n_r && i_spi_frame_valid) ||
               (mode_r != OPMHC_INIT && mode_r != OPMHC_NORMAL))
         dev_window_r <= 1'b0;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst)
         dev_r <= 1'b0;
      else if (dev_window_r && rst_n_r && !test_s2_r && i_spi_frame_valid &&
               (mode_r == OPMHC_INIT || mode_r == OPMHC_NORMAL))
         dev_r <= 1'b1;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst)
         wd_rst_en_r <= 1'b0;
      else if (dev_r && i_wd_reset_reenable)
         wd_rst_en_r <= 1'b1;
   end

   // interrupt pin is open drain, pulled low for one cycle per wd fail in dev mode while wd reset is not re-enabled
   always_ff @(posedge i_clk) begin
      if (i_rst)
         int_r <= 1'b0;
      else
         int_r <= i_wd_fail && dev_r && !wd_rst_en_r;
   end

   // long open window restarts after every reset release
   always_ff @(posedge i_clk) begin
      if (i_rst)
         wd_long_r <= 1'b0;
      else if (rst_rise)
         wd_long_r <= 1'b1;
      else if (mode_r == OPMHC_NORMAL)
         wd_long_r <= 1'b0;
   end

   assign o_mode = mode_r;
   assign o_main_regulator_output = reg_on_r;
   assign o_micro_reset_out_n = rst_n_r;
   assign o_int_out = 1'b0;
   assign o_int_out_oe = int_r;
   assign o_wd_long_window = wd_long_r;
   assign o_dev_mode = dev_r;
   assign o_crc_en = crc_r;
endmodule

/* File: sim/opmhc_micro.sv */
// microcontroller model: one decoded spi frame strobe per send request
`timescale 1ns/100ps
module opmhc_micro (
   input wire logic i_clk, i_send,
   input wire logic [31:0] i_word,
   output logic o_valid = 1'b0,
   output logic [31:0] o_frame = 32'h0000_0000
);
   // word not held past the strobe: inverted every cycle after it, so a sample one cycle late cannot match
   always @(posedge i_clk) begin
      o_valid <= i_send;
      o_frame <= i_send ? i_word : ~o_frame;
   end
endmodule

/* File: sim/opmhc_top_props.sv */
// port assertions for the operating mode controller
`timescale 1ns/100ps
module opmhc_top_props import opmhc_pkg::*;
#(parameter int RST_DELAY_CYC = 4) (
   input wire logic i_clk, i_rst, i_wake, i_soft_reset, i_critical_fail,
   input wire logic i_spi_frame_valid,
   input wire logic [31:0] i_spi_frame,
   input wire opmhc_mode_t o_mode,
   input wire logic o_main_regulator_output, o_micro_reset_out_n, o_crc_en
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   property p_st; o_mode == OPMHC_STOP |-> o_main_regulator_output; endproperty
   a_st: assert property (p_st) else $error("stop reg off");
   property p_sl; o_mode == OPMHC_SLEEP |-> !o_main_regulator_output;
   endproperty
   a_sl: assert property (p_sl) else $error("sleep reg on");
   property p_sr; i_soft_reset && !i_critical_fail |=> o_mode == OPMHC_INIT;
   endproperty
   a_sr: assert property (p_sr) else $error("no init");
   property p_cf; i_critical_fail |=> o_mode == OPMHC_FAILSAFE; endproperty
   a_cf: assert property (p_cf) else $error("no fail-safe");
   property p_wk; i_wake && !i_critical_fail && !i_soft_reset &&
      o_mode == OPMHC_SLEEP |=> o_mode == OPMHC_RESTART; endproperty
   a_wk: assert property (p_wk) else $error("no restart");
   property p_rl; o_mode == OPMHC_RESTART |-> !o_micro_reset_out_n; endproperty
   a_rl: assert property (p_rl) else $error("micro not reset");
   // the micro must have seen the full reset delay before release
   property p_rn; $rose(o_micro_reset_out_n) |-> o_mode == OPMHC_NORMAL &&
      $past(o_micro_reset_out_n, RST_DELAY_CYC) == 1'b0; endproperty
   a_rn: assert property (p_rn) else $error("reset too short");
   property p_cr; i_spi_frame_valid && o_mode == OPMHC_NORMAL &&
      i_spi_frame inside {32'h67AA_AA0E, 32'hE7AA_AAC3}
      |=> o_crc_en == !$past(i_spi_frame[31]); endproperty
   a_cr: assert property (p_cr) else $error("crc frame");
endmodule
bind opmhc_top opmhc_top_props #(.RST_DELAY_CYC(RST_DELAY_CYC)) i_props (.*);

/* File: sim/opmhc_top_tb.sv */
// self-checking bench for the operating mode controller
`timescale 1ns/100ps
module opmhc_top_tb;
   import opmhc_pkg::*;
   logic clk = 0, rst = 1, strap = 0, snd = 0, fv, crc, urst_n, reg_on;
   logic tpin = 1, reen = 0, iout, ioe, wlw, dev;
   logic [7:0] ev = 8'h00;
   logic [31:0] wd = 32'h0000_0000, fr;
   opmhc_mode_t md;
   int n_mismatch = 0, cmp_count = 0, cyc = 0;
   // {soft,normal,stop,sleep,wake,wdf,uv,crit} pulses, then expected mode
   logic [10:0] rows [11] = '{11'h082, 11'h046, 11'h103, 11'h201, 11'h041,
      11'h103, 11'h016, 11'h026, 11'h40f, 11'h046, 11'h400};
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) final_report(1);
   end
   opmhc_micro i_opmhc_micro (.i_clk(clk), .i_send(snd), .i_word(wd),
      .o_valid(fv), .o_frame(fr));
   opmhc_top #(.RST_DELAY_CYC(4)) i_opmhc_top (.i_clk(clk), .i_rst(rst),
      .i_soft_reset(ev[7]), .i_go_normal(ev[6]), .i_go_stop(ev[5]),
      .i_go_sleep(ev[4]), .i_wake(ev[3]), .i_wd_fail(ev[2]),
      .i_undervoltage(ev[1]), .i_critical_fail(ev[0]), .i_test_pin(tpin),
      .i_wd_reset_reenable(reen), .i_spi_frame_valid(fv), .i_spi_frame(fr),
      .i_pwm_in1_checksum_strap_pin(strap), .o_mode(md), .o_crc_en(crc),
      .o_main_regulator_output(reg_on), .o_micro_reset_out_n(urst_n),
      .o_int_out(iout), .o_int_out_oe(ioe), .o_wd_long_window(wlw),
      .o_dev_mode(dev));
   task chk(input logic [2:0] g, input logic [2:0] e);
      cmp_count++;
      if (g !== e) n_mismatch++;
      if (g !== e) $display("ERROR %0t got %0d expected %0d", $time, g, e);
   endtask
   task pulse(input logic [7:0] e, input logic [31:0] w);
      @(posedge clk) ev <= e;
      {snd, wd} <= {|w, w};
      @(posedge clk) {ev, snd} <= 9'h000;
      #1;
   endtask
   task wait_up;
      for (int k = 0; k < 40 && urst_n !== 1'b1; k++) begin
         @(posedge clk);
         #1;
      end
      chk(md, OPMHC_NORMAL);
      chk(wlw, 1'b1);
   endtask
   task final_report(input int extra);
      n_mismatch += extra;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      #1;
      chk({md, urst_n, reg_on} == {OPMHC_INIT, 2'b01}, 1'b1);
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      wait_up;
      chk(crc, 1'b1);
      for (int i = 0; i < 11; i++) begin
         pulse(rows[i][10:3], 32'h0000_0000);
         chk(md, rows[i][2:0]);
         if (md == OPMHC_RESTART || md == OPMHC_INIT) wait_up;
      end
      $display("mode rows done");
      pulse(8'h00, 32'hE7AA_AAC3);
      pulse(8'h00, 32'h0000_0000);
      chk(crc, 1'b0);
      pulse(8'h00, 32'h67AA_AA0E);
      pulse(8'h00, 32'h0000_0000);
      chk(crc, 1'b1);
      @(posedge clk) strap <= 1'b1;
      pulse(8'h10, 32'h0000_0000);
      pulse(8'h08, 32'h0000_0000);
      wait_up;
      chk(crc, 1'b0);
      $display("crc test done");
      @(posedge clk) begin
         rst <= 1'b1;
         tpin <= 1'b0;
      end
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      wait_up;
      pulse(8'h00, 32'h0000_0001);
      pulse(8'h00, 32'h0000_0000);
      chk(dev, 1'b1);
      pulse(8'h04, 32'h0000_0000);
      chk(md, OPMHC_NORMAL);
      chk(ioe, 1'b1);
      chk(iout, 1'b0);
      @(posedge clk) reen <= 1'b1;
      pulse(8'h04, 32'h0000_0000);
      chk(md, OPMHC_RESTART);
      wait_up;
      chk(dev, 1'b1);
      $display("dev mode test done");
      final_report(0);
   end
endmodule
